// ===== ucr_pkg.sv
package ucr_pkg;
    localparam logic [2:0] OFS_DATA     = 3'h0;
    localparam logic [2:0] OFS_IRQ_EN   = 3'h1;
    localparam logic [2:0] OFS_IDENT    = 3'h2;
    localparam logic [2:0] OFS_LINE_CTL = 3'h3;
    localparam logic [2:0] OFS_MODEM_CTL= 3'h4;
    localparam logic [2:0] OFS_LINE_STS = 3'h5;
    localparam logic [2:0] OFS_MODEM_STS= 3'h6;
    localparam logic [2:0] OFS_SPARE    = 3'h7;
    localparam int         DIV_ACC_BIT  = 7;
    localparam int         FIFO_WIDTH   = 8;
    localparam int         FIFO_DEPTH   = 32;
    localparam logic [7:0] LSR_RESET    = 8'h60;
    localparam logic [2:0] ID_NONE      = 3'h0;
    localparam logic [2:0] ID_MODEM     = 3'h0;
    localparam logic [2:0] ID_TX_HOLDING_EMPTY      = 3'h1;
    localparam logic [2:0] ID_RXAV      = 3'h2;
    localparam logic [2:0] ID_LINE      = 3'h3;
    localparam logic [2:0] ID_TIMEOUT   = 3'h6;
    localparam logic [3:0] OVERSAMPLE   = 4'hF;
    localparam logic [5:0] TIMEOUT_BITS = 6'h28;
endpackage : ucr_pkg

// ===== ucr_stream_if.sv
`timescale 1ns/1ps
interface ucr_stream_if;
    logic       valid;
    logic       ready;
    logic [7:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : ucr_stream_if

// ===== ucr_fifo.sv
`timescale 1ns/1ps
module ucr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    // clocking
    input  wire logic    clk,
    input  wire logic    rst_n,
    input  wire logic    ce,
    input  wire logic    flush,
    // streams
    ucr_stream_if.snk    wr,
    ucr_stream_if.src    rd,
    // fill
    output      logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0]   cnt;
    } ucr_fifo_s;
    ucr_fifo_s          st;
    ucr_fifo_s          next_st;
    logic [WIDTH-1:0]   mem [DEPTH];
    logic               push;
    logic               pop;

    // honest flags: full stalls the writer, empty hides data
    assign push     = wr.valid && (st.cnt != DEPTH[AW:0]);
    assign pop      = rd.ready && (st.cnt != '0);
    assign wr.ready = (st.cnt != DEPTH[AW:0]);
    assign rd.valid = (st.cnt != '0);
    assign rd.data  = mem[st.rp];
    assign level    = st.cnt;

    always_comb begin
        next_st = st;
        if (flush) begin
            next_st = '0;
        end else begin
            if (push) next_st.wp = st.wp + 1'b1;
            if (pop)  next_st.rp = st.rp + 1'b1;
            next_st.cnt = st.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) st <= '0;
        else if (ce) st <= next_st;
    end

    // storage has no reset, only the pointers matter
    always_ff @(posedge clk) begin
        if (ce && push && !flush) mem[st.wp] <= wr.data;
    end
endmodule : ucr_fifo

// ===== ucr_channel.sv
`timescale 1ns/1ps
module ucr_channel (
    // clock, reset, enable
    input  wire logic       CORE_CLK,
    input  wire logic       RESET_N,
    input  wire logic       CLK_EN,
    // host register port
    input  wire logic [2:0] ADDR,
    input  wire logic       RD_STB,
    input  wire logic       WR_STB,
    input  wire logic [7:0] WR_DATA,
    output      logic [7:0] RD_DATA,
    // mode strap
    input  wire logic       LEGACY_BUS_MODE,
    // serial and modem lines
    output      logic       TXD,
    input  wire logic       RXD,
    output      logic       RTS_N,
    output      logic       DTR_N,
    input  wire logic       CTS_N,
    input  wire logic       DSR_N,
    input  wire logic       RI_N,
    input  wire logic       DCD_N,
    // interrupt request
    output      logic       IRQ
);
    typedef enum logic [1:0] {
        SH_IDLE  = 2'b00,
        SH_START = 2'b01,
        SH_DATA  = 2'b10,
        SH_STOP  = 2'b11
    } ucr_shift_e;

    typedef struct packed {
        logic [7:0]  irq_en;
        logic [7:0]  line_ctl;
        logic [7:0]  modem_ctl;
        logic [7:0]  spare;
        logic [15:0] divisor;
        logic        fifo_on;
        logic [1:0]  trig;
        logic        tx_holding_empty_irq;
        logic [3:0]  line_err;
        logic        overrun;
        logic        rx_fifo_err;
        logic [3:0]  modem_delta;
        logic [3:0]  modem_prev;
        logic [15:0] baud_cnt;
        logic        tick;
        ucr_shift_e  tx_st;
        logic [3:0]  tx_sub;
        logic [2:0]  tx_bit;
        logic [7:0]  tx_sh;
        logic        txd;
        ucr_shift_e  rx_st;
        logic [3:0]  rx_sub;
        logic [2:0]  rx_bit;
        logic [7:0]  rx_sh;
        logic        rx_was_low;
        logic [5:0]  to_bits;
        logic [3:0]  to_sub;
        logic        to_irq;
        logic [7:0]  rd_data;
        logic        irq;
        logic        pin_txd;
        logic [1:0]  pins_n;
    } ucr_state_s;

    ucr_state_s st;
    ucr_state_s next_st;

    ucr_stream_if tx_in ();
    ucr_stream_if tx_out ();
    ucr_stream_if rx_in ();
    ucr_stream_if rx_out ();
    logic [5:0] tx_lvl;
    logic [5:0] rx_lvl;
    logic       flush_tx;
    logic       flush_rx;

    // decode of a host access, used by several consumers
    function automatic logic hit(input logic stb, input logic [2:0] a,
                                 input logic [2:0] want);
        return stb && (a == want);
    endfunction : hit

    // receive trigger level in bytes, kept small for the 32 word queue
    function automatic logic [5:0] trig_level(input logic [1:0] t);
        unique case (t)
            2'b00: return 6'h01;
            2'b01: return 6'h04;
            2'b10: return 6'h08;
            2'b11: return 6'h0E;
        endcase
    endfunction : trig_level

    logic       dla;
    logic       wr_fcr;
    logic       rd_rbr;
    logic       rd_iir;
    logic       rd_lsr;
    logic       rd_msr;
    logic       loop;
    logic       rx_line;
    logic       rx_avail;
    logic       line_irq;
    logic       modem_irq;
    logic [2:0] ident;
    logic       pend;
    logic [3:0] modem_in;
    logic [7:0] line_status;
    logic [7:0] interrupt_identity;
    logic [7:0] modem_status;

    assign dla      = st.line_ctl[ucr_pkg::DIV_ACC_BIT];
    assign wr_fcr   = hit(WR_STB, ADDR, ucr_pkg::OFS_IDENT);
    assign rd_rbr   = hit(RD_STB, ADDR, ucr_pkg::OFS_DATA) && !dla;
    assign rd_iir   = hit(RD_STB, ADDR, ucr_pkg::OFS_IDENT);
    assign rd_lsr   = hit(RD_STB, ADDR, ucr_pkg::OFS_LINE_STS);
    assign rd_msr   = hit(RD_STB, ADDR, ucr_pkg::OFS_MODEM_STS);
    assign loop     = st.modem_ctl[4];
    assign flush_rx = wr_fcr && (WR_DATA[1] || !WR_DATA[0]);
    assign flush_tx = wr_fcr && (WR_DATA[2] || !WR_DATA[0]);
    assign rx_line  = loop ? st.txd : RXD;

    // transmit queue: host writes fill it, the shifter drains it
    assign tx_in.valid = hit(WR_STB, ADDR, ucr_pkg::OFS_DATA) && !dla;
    assign tx_in.data  = WR_DATA;
    assign tx_out.ready = st.tick && (st.tx_st == SH_IDLE);

    // receive queue: full refuses and raises overrun
    assign rx_in.valid = st.tick && (st.rx_st == SH_STOP)
                         && (st.rx_sub == 4'h7);
    assign rx_in.data  = st.rx_sh;
    assign rx_out.ready = rd_rbr;

    ucr_fifo #(
        .WIDTH (ucr_pkg::FIFO_WIDTH),
        .DEPTH (ucr_pkg::FIFO_DEPTH)
    ) u_tx_fifo (
        .clk   (CORE_CLK),
        .rst_n (RESET_N),
        .ce    (CLK_EN),
        .flush (flush_tx),
        .wr    (tx_in),
        .rd    (tx_out),
        .level (tx_lvl)
    );

    ucr_fifo #(
        .WIDTH (ucr_pkg::FIFO_WIDTH),
        .DEPTH (ucr_pkg::FIFO_DEPTH)
    ) u_rx_fifo (
        .clk   (CORE_CLK),
        .rst_n (RESET_N),
        .ce    (CLK_EN),
        .flush (flush_rx),
        .wr    (rx_in),
        .rd    (rx_out),
        .level (rx_lvl)
    );

    // modem inputs, looped back from control bits in loopback
    assign modem_in = loop ? {st.modem_ctl[3], st.modem_ctl[2],
                              st.modem_ctl[0], st.modem_ctl[1]}
                           : {~DCD_N, ~RI_N, ~DSR_N, ~CTS_N};
    assign modem_status = {modem_in, st.modem_delta};

    // status view; transmitter-idle tracks the shifter, and outside legacy mode also needs an empty transmit queue
    always_comb begin
        line_status    = '0;
        line_status[0] = (rx_lvl != '0);
        line_status[1] = st.overrun;
        line_status[4:2] = st.line_err[2:0];
        line_status[5] = (tx_lvl == '0);
        line_status[6] = (st.tx_st == SH_IDLE)
                 && (LEGACY_BUS_MODE || tx_lvl == '0);
        line_status[7] = st.fifo_on && st.rx_fifo_err;
    end

    // priority: line status, then data/timeout, then holding, then modem
    assign line_irq  = st.irq_en[2] && (st.overrun || (st.line_err != '0));
    assign rx_avail  = st.irq_en[0] &&
                       (st.fifo_on ? (rx_lvl >= trig_level(st.trig))
                                   : (rx_lvl != '0));
    assign modem_irq = st.irq_en[3] && (st.modem_delta != '0);
    always_comb begin
        pend  = 1'b1;
        ident = ucr_pkg::ID_NONE;
        if (line_irq) ident = ucr_pkg::ID_LINE;
        else if (st.to_irq && st.irq_en[0]) ident = ucr_pkg::ID_TIMEOUT;
        else if (rx_avail) ident = ucr_pkg::ID_RXAV;
        else if (st.tx_holding_empty_irq && st.irq_en[1]) ident = ucr_pkg::ID_TX_HOLDING_EMPTY;
        else if (modem_irq) ident = ucr_pkg::ID_MODEM;
        else pend = 1'b0;
    end
    // fifo-only bits masked in plain mode
    assign interrupt_identity = {st.fifo_on, st.fifo_on, 2'b00,
                  ident[2] && st.fifo_on, ident[1:0], !pend};

    always_comb begin
        next_st = st;
        // baud: one tick per divisor count, sixteen per bit
        next_st.tick = 1'b0;
        if (st.baud_cnt >= st.divisor - 16'h0001) begin
            next_st.baud_cnt = '0;
            next_st.tick     = (st.divisor != '0);
        end else begin
            next_st.baud_cnt = st.baud_cnt + 16'h0001;
        end

        // register writes
        if (WR_STB) begin
            unique case (ADDR)
                ucr_pkg::OFS_DATA:     if (dla) next_st.divisor[7:0] = WR_DATA;
                ucr_pkg::OFS_IRQ_EN:
                    if (dla) next_st.divisor[15:8] = WR_DATA;
                    else     next_st.irq_en = {4'h0, WR_DATA[3:0]};
                ucr_pkg::OFS_IDENT: begin
                    // dma select bit 3 is dropped on purpose
                    next_st.fifo_on = WR_DATA[0];
                    next_st.trig    = WR_DATA[7:6];
                end
                ucr_pkg::OFS_LINE_CTL:  next_st.line_ctl = WR_DATA;
                ucr_pkg::OFS_MODEM_CTL:
                    next_st.modem_ctl = {3'h0, WR_DATA[4:0]};
                ucr_pkg::OFS_SPARE:
                    if (!LEGACY_BUS_MODE) next_st.spare = WR_DATA;
                default: ;
            endcase
        end

        // holding-empty request: set on drain, cleared by write or ident read
        if ((rd_iir && ident == ucr_pkg::ID_TX_HOLDING_EMPTY) || tx_in.valid)
            next_st.tx_holding_empty_irq = 1'b0;
        if (tx_out.ready && tx_out.valid && tx_lvl == 6'h01)
            next_st.tx_holding_empty_irq = 1'b1;

        // modem deltas: set wins over clearing read
        if (rd_msr) next_st.modem_delta = '0;
        next_st.modem_prev = modem_in;
        next_st.modem_delta = next_st.modem_delta |
            {st.modem_prev[3] ^ modem_in[3],
             st.modem_prev[2] & ~modem_in[2],
             st.modem_prev[1] ^ modem_in[1],
             st.modem_prev[0] ^ modem_in[0]};

        // line errors cleared by status read, new error wins
        if (rd_lsr) begin
            next_st.line_err    = '0;
            next_st.overrun     = 1'b0;
            next_st.rx_fifo_err = 1'b0;
        end

        // transmit shifter, lsb first
        if (st.tick) begin
            next_st.tx_sub = st.tx_sub + 4'h1;
            unique case (st.tx_st)
                SH_IDLE: begin
                    next_st.tx_sub = '0;
                    if (tx_out.valid) begin
                        next_st.tx_sh = tx_out.data;
                        next_st.tx_st = SH_START;
                        next_st.txd   = 1'b0;
                    end
                end
                SH_START: if (st.tx_sub == ucr_pkg::OVERSAMPLE) begin
                    next_st.tx_st  = SH_DATA;
                    next_st.tx_bit = '0;
                    next_st.txd    = st.tx_sh[0];
                end
                SH_DATA: if (st.tx_sub == ucr_pkg::OVERSAMPLE) begin
                    next_st.tx_sh  = {1'b0, st.tx_sh[7:1]};
                    next_st.tx_bit = st.tx_bit + 3'h1;
                    if (st.tx_bit == 3'h7) begin
                        next_st.tx_st = SH_STOP;
                        next_st.txd   = 1'b1;
                    end else begin
                        next_st.txd = st.tx_sh[1];
                    end
                end
                SH_STOP: if (st.tx_sub == ucr_pkg::OVERSAMPLE)
                    next_st.tx_st = SH_IDLE;
            endcase
        end

        // receive shifter, mid-bit sampling of start and data, stop checked eight ticks after the last data sample
        if (st.tick) begin
            next_st.rx_sub = st.rx_sub + 4'h1;
            next_st.rx_was_low = !rx_line;  // a held-low line is no start
            unique case (st.rx_st)
                SH_IDLE: begin
                    next_st.rx_sub = '0;
                    if (!rx_line && !st.rx_was_low) next_st.rx_st = SH_START;
                end
                SH_START: if (st.rx_sub == 4'h7) begin
                    next_st.rx_sub = '0;
                    next_st.rx_bit = '0;
                    next_st.rx_st  = rx_line ? SH_IDLE : SH_DATA;
                end
                SH_DATA: if (st.rx_sub == ucr_pkg::OVERSAMPLE) begin
                    next_st.rx_sh  = {rx_line, st.rx_sh[7:1]};
                    next_st.rx_bit = st.rx_bit + 3'h1;
                    if (st.rx_bit == 3'h7) next_st.rx_st = SH_STOP;
                end
                SH_STOP: if (st.rx_sub == 4'h7) begin
                    next_st.rx_st = SH_IDLE;
                    if (!rx_line) begin
                        next_st.line_err[1] = 1'b1;
                        next_st.rx_fifo_err = 1'b1;
                        if (st.rx_sh == '0) next_st.line_err[2] = 1'b1;
                    end
                    if (!rx_in.ready) next_st.overrun = 1'b1;
                end
            endcase
        end

        // timeout: own sixteen-tick bit count, the receiver's rests idle
        if (rx_in.valid || rd_rbr || rx_lvl == '0 || !st.fifo_on) begin
            next_st.to_bits = '0;
            next_st.to_sub  = '0;
            next_st.to_irq  = 1'b0;
        end else if (st.to_bits == ucr_pkg::TIMEOUT_BITS) begin
            next_st.to_irq = 1'b1;
        end else if (st.tick) begin
            next_st.to_sub = st.to_sub + 4'h1;
            if (st.to_sub == ucr_pkg::OVERSAMPLE)
                next_st.to_bits = st.to_bits + 6'h01;
        end

        // read mux, registered
        next_st.rd_data = '0;
        unique case (ADDR)
            ucr_pkg::OFS_DATA:
                next_st.rd_data = dla ? st.divisor[7:0] : rx_out.data;
            ucr_pkg::OFS_IRQ_EN:
                next_st.rd_data = dla ? st.divisor[15:8] : st.irq_en;
            ucr_pkg::OFS_IDENT:     next_st.rd_data = interrupt_identity;
            ucr_pkg::OFS_LINE_CTL:  next_st.rd_data = st.line_ctl;
            ucr_pkg::OFS_MODEM_CTL: next_st.rd_data = st.modem_ctl;
            ucr_pkg::OFS_LINE_STS:  next_st.rd_data = line_status;
            ucr_pkg::OFS_MODEM_STS: next_st.rd_data = modem_status;
            ucr_pkg::OFS_SPARE:
                next_st.rd_data = LEGACY_BUS_MODE ? 8'h00 : st.spare;
        endcase
        if (!RD_STB) next_st.rd_data = st.rd_data;
        next_st.irq = pend;
        // pin flops; loopback parks the line and the modem outputs
        next_st.pin_txd = next_st.txd | next_st.modem_ctl[4];
        next_st.pins_n  = ~next_st.modem_ctl[1:0] | {2{next_st.modem_ctl[4]}};
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            st          <= '0;
            st.txd      <= 1'b1;
            st.pin_txd  <= 1'b1;
            st.pins_n   <= 2'b11;
        end else if (CLK_EN) begin
            st <= next_st;
        end
    end

    // pins come from state flops; user outputs stay internal
    assign RD_DATA = st.rd_data;
    assign TXD     = st.pin_txd;
    assign RTS_N   = st.pins_n[1];
    assign DTR_N   = st.pins_n[0];
    assign IRQ     = st.irq;
endmodule : ucr_channel

// ===== ucr_channel_sva.sv
`timescale 1ns/1ps
module ucr_channel_sva (
    // clock and reset
    input  wire logic       CORE_CLK,
    input  wire logic       RESET_N,
    input  wire logic       CLK_EN,
    // host register port
    input  wire logic [2:0] ADDR,
    input  wire logic       RD_STB,
    input  wire logic       WR_STB,
    input  wire logic [7:0] WR_DATA,
    input  wire logic [7:0] RD_DATA,
    // strap and lines
    input  wire logic       LEGACY_BUS_MODE,
    input  wire logic       TXD,
    input  wire logic       RXD,
    input  wire logic       RTS_N,
    input  wire logic       DTR_N
);
    logic       rd;
    logic       wr;
    logic       fifo_on;
    logic       lcr7;
    logic       fresh;
    logic [7:0] mc_w;
    logic [7:0] div_lo;

    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!RESET_N);

    // accepted strobes only; a frozen clock enable takes nothing
    assign rd = RD_STB && CLK_EN;
    assign wr = WR_STB && CLK_EN;

    // shadow of host writes, so reads can be judged without the bodies
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            fifo_on <= 1'b0;
            lcr7    <= 1'b0;
            fresh   <= 1'b1;
            mc_w    <= 8'h00;
            div_lo  <= 8'h00;
        end else begin
            fresh <= fresh && !wr && RXD;  // any traffic spoils reset image
            if (wr && ADDR == 3'h2) fifo_on <= WR_DATA[0];
            if (wr && ADDR == 3'h3) lcr7 <= WR_DATA[7];
            if (wr && ADDR == 3'h4) mc_w <= WR_DATA;
            if (wr && ADDR == 3'h0 && lcr7) div_lo <= WR_DATA;
        end
    end

    chk_scratch_gone: assert property (
        rd && ADDR == 3'h7 && LEGACY_BUS_MODE |=> RD_DATA == 8'h00)
        else $error("spare byte visible in legacy mode");
    chk_ident_zeros: assert property (
        rd && ADDR == 3'h2 |=> RD_DATA[5:4] == 2'b00)
        else $error("identity bits 5:4 not zero");
    chk_ident_nofifo: assert property (
        rd && ADDR == 3'h2 && !fifo_on |=> !RD_DATA[7] && !RD_DATA[6]
        && !RD_DATA[3])
        else $error("identity fifo bits set with fifos off");
    chk_lsr_nofifo: assert property (
        rd && ADDR == 3'h5 && !fifo_on |=> !RD_DATA[7])
        else $error("status bit 7 set with fifos off");
    chk_lsr_reset: assert property (
        rd && ADDR == 3'h5 && fresh |=> RD_DATA == 8'h60)
        else $error("line status reset image wrong");
    chk_div_low: assert property (
        rd && ADDR == 3'h0 && lcr7 |=> RD_DATA == div_lo)
        else $error("divisor low byte readback wrong");
    chk_mc_read: assert property (
        rd && ADDR == 3'h4 |=> RD_DATA == (mc_w & 8'h1F))
        else $error("modem control readback wrong");
    chk_rts_pin: assert property (
        wr && ADDR == 3'h4 ##1 1'b1 |=> RTS_N == (!mc_w[1] || mc_w[4]))
        else $error("request-to-send pin wrong");
    chk_dtr_pin: assert property (
        wr && ADDR == 3'h4 ##1 1'b1 |=> DTR_N == (!mc_w[0] || mc_w[4]))
        else $error("terminal-ready pin wrong");
    chk_loop_txd: assert property (
        mc_w[4] && $past(mc_w[4]) |-> TXD)
        else $error("serial out not held high in loopback");
endmodule : ucr_channel_sva

bind ucr_channel ucr_channel_sva chk_u (
    .CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .CLK_EN(CLK_EN),
    .ADDR(ADDR), .RD_STB(RD_STB), .WR_STB(WR_STB), .WR_DATA(WR_DATA),
    .RD_DATA(RD_DATA), .LEGACY_BUS_MODE(LEGACY_BUS_MODE), .TXD(TXD),
    .RXD(RXD), .RTS_N(RTS_N), .DTR_N(DTR_N)
);

// ===== ucr_serial_peer.sv
`timescale 1ns/1ps
module ucr_serial_peer #(
    parameter int BIT_CYC = 16
) (
    // clock and serial lines
    input  wire logic clk,
    input  wire logic txd,
    output      logic rxd
);
    logic [7:0] rx_q[$];

    // line rests at the marking level
    initial rxd = 1'b1;

    // one 8N1 character, low bit first; a low stop bit forces a frame error
    task automatic send(input logic [7:0] b, input logic stop);
        logic [9:0] f;
        f = {stop, b, 1'b0};
        for (int i = 0; i < 11; i++) begin
            rxd = (i < 10) ? f[i] : 1'b1;  // one idle bit keeps frames apart
            repeat (BIT_CYC) @(posedge clk);
            #1;
        end
    endtask : send

    // capture what the channel sends, sampled mid-bit
    initial begin
        logic [7:0] b;
        forever begin
            @(negedge txd);
            repeat (BIT_CYC / 2) @(posedge clk);
            for (int i = 0; i < 8; i++) begin
                repeat (BIT_CYC) @(posedge clk);
                b[i] = txd;
            end
            repeat (BIT_CYC) @(posedge clk);
            rx_q.push_back(b);
        end
    end
endmodule : ucr_serial_peer

// ===== tb.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin \
    failures++; $display("CHECK FAILED t=%0t got=%h exp=%h", \
    $time, got, exp); end end
module tb;
    localparam int BIT_CYC = 16;  // divisor 1: sixteen clocks per bit
    logic       core_clk, reset_n, rd_stb, wr_stb, legacy, clk_en;
    logic       rxd, txd, rts_n, dtr_n, irq;
    logic [2:0] addr;
    logic [7:0] wr_data, rd_data, v, r, e;
    logic [3:0] modem_in;
    int         failures = 0, checked = 0, cycles = 0, seed, n;

    ucr_channel dut_u (
        .CORE_CLK(core_clk), .RESET_N(reset_n), .CLK_EN(clk_en),
        .ADDR(addr), .RD_STB(rd_stb), .WR_STB(wr_stb), .WR_DATA(wr_data),
        .RD_DATA(rd_data), .LEGACY_BUS_MODE(legacy), .TXD(txd), .RXD(rxd),
        .RTS_N(rts_n), .DTR_N(dtr_n), .CTS_N(modem_in[0]),
        .DSR_N(modem_in[1]), .RI_N(modem_in[2]), .DCD_N(modem_in[3]),
        .IRQ(irq)
    );
    ucr_serial_peer #(.BIT_CYC(BIT_CYC)) peer_u (
        .clk(core_clk), .txd(txd), .rxd(rxd)
    );

    // 250 MHz core clock
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    // hang guard, well above the longest sequence
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 40000) begin
            failures++;
            end_sim();
        end
    end

    task automatic end_sim;
        if (failures == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_sim

    // host accesses: entered at edge+1, strobe held over exactly one edge
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        addr = a;
        wr_data = d;
        wr_stb = 1'b1;
        @(posedge core_clk);
        #1 wr_stb = 1'b0;
        @(posedge core_clk);
        #1;
    endtask : wr

    task automatic rchk(input logic [2:0] a, input logic [7:0] m, x);
        addr = a;
        rd_stb = 1'b1;
        @(posedge core_clk);
        #1 rd_stb = 1'b0;
        r = rd_data;  // registered answer of the edge just passed
        `CHK(r & m, x)
        @(posedge core_clk);
        #1;
    endtask : rchk

    task automatic wait_q(input int k);
        for (int i = 0; i < 8000 && peer_u.rx_q.size() < k; i++)
            @(posedge core_clk);
        #1;
    endtask : wait_q

    task automatic idle(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask : idle

    // expected identity byte from fifo state, code and pending flag
    function automatic logic [7:0] ident(input logic f, input logic [2:0] id,
                                         input logic p);
        return {f, f, 2'b00, id, ~p};
    endfunction : ident

    initial begin
        seed = 32'hd02f2a5d;
        {reset_n, rd_stb, wr_stb, legacy, addr, wr_data} = '0;
        modem_in = 4'hF;
        clk_en = 1'b1;
        idle(20);
        reset_n = 1'b1;
        modem_in = 4'($random(seed));
        rchk(3'h5, 8'hFF, 8'h60);
        rchk(3'h2, 8'hFF, ident(1'b0, ucr_pkg::ID_NONE, 1'b0));
        // divisor bytes shadow data and enable offsets
        wr(3'h3, 8'h80);
        wr(3'h0, 8'h01);
        wr(3'h1, 8'hA5);
        rchk(3'h0, 8'hFF, 8'h01);
        rchk(3'h1, 8'hFF, 8'hA5);
        wr(3'h1, 8'h00);
        wr(3'h3, 8'h03);
        rchk(3'h1, 8'hFF, 8'h00);
        // modem control: user bits kept, pins follow, loopback parks them
        for (n = 0; n < 12; n++) begin
            v = (n == 0) ? 8'h0C : 8'($random(seed));
            wr(3'h4, v);
            rchk(3'h4, 8'hFF, v & 8'h1F);
            `CHK({rts_n, dtr_n}, {~v[1] | v[4], ~v[0] | v[4]})
        end
        wr(3'h4, 8'h00);
        wr(3'h7, 8'hA5);
        rchk(3'h7, 8'hFF, 8'hA5);
        // a write under a low clock enable must leave the byte alone
        clk_en = 1'b0;
        wr(3'h7, 8'h5A);
        clk_en = 1'b1;
        rchk(3'h7, 8'hFF, 8'hA5);
        legacy = 1'b1;
        wr(3'h7, 8'h3C);
        rchk(3'h7, 8'hFF, 8'h00);
        v = 8'($random(seed));
        wr(3'h0, v);
        wait_q(1);
        e = peer_u.rx_q.pop_front();
        `CHK(e, v)
        idle(BIT_CYC);  // let the stop bit finish
        rchk(3'h5, 8'h60, 8'h60);
        legacy = 1'b0;
        // a write at offset 0 must not disturb the receive side
        v = 8'($random(seed));
        peer_u.send(v, 1'b1);
        wr(3'h0, ~v);
        rchk(3'h0, 8'hFF, v);
        wait_q(1);
        e = peer_u.rx_q.pop_front();
        `CHK(e, ~v)
        peer_u.send(8'h55, 1'b0);
        rchk(3'h5, 8'h89, 8'h09);
        rchk(3'h0, 8'hFF, 8'h55);
        // fifo mode, trigger four, dma select has no effect
        wr(3'h2, 8'h07);
        rchk(3'h2, 8'hFF, ident(1'b1, ucr_pkg::ID_NONE, 1'b0));
        wr(3'h2, 8'h49);
        rchk(3'h2, 8'hFF, 8'hC1);
        wr(3'h1, 8'h05);
        for (n = 0; n < 4; n++) begin
            peer_u.send(8'h10 + n[7:0], 1'b1);
            rchk(3'h2, 8'hFF, ident(1'b1, (n == 3) ? ucr_pkg::ID_RXAV :
                 ucr_pkg::ID_NONE, n == 3));
            `CHK(irq, n == 3)
        end
        rchk(3'h0, 8'hFF, 8'h10);
        rchk(3'h2, 8'hFF, 8'hC1);
        idle(32 * BIT_CYC);
        rchk(3'h2, 8'hFF, 8'hC1);
        idle(16 * BIT_CYC);
        rchk(3'h2, 8'hFF, ident(1'b1, ucr_pkg::ID_TIMEOUT, 1'b1));
        for (n = 1; n < 4; n++)
            rchk(3'h0, 8'hFF, 8'h10 + n[7:0]);
        // error outranks data available at trigger one
        wr(3'h2, 8'h01);
        peer_u.send(8'h33, 1'b0);
        rchk(3'h2, 8'hFF, 8'hC6);
        rchk(3'h5, 8'h89, 8'h89);
        rchk(3'h2, 8'hFF, 8'hC4);
        rchk(3'h0, 8'hFF, 8'h33);
        // transmit queue filled past capacity with the baud ticks stopped
        wr(3'h3, 8'h83);
        wr(3'h0, 8'h00);
        wr(3'h3, 8'h03);
        for (n = 0; n < 40; n++)
            wr(3'h0, n[7:0]);
        rchk(3'h5, 8'h60, 8'h00);
        legacy = 1'b1;
        rchk(3'h5, 8'h40, 8'h40);
        legacy = 1'b0;
        wr(3'h3, 8'h83);
        wr(3'h0, 8'h01);
        wr(3'h3, 8'h03);
        wait_q(33);
        `CHK(peer_u.rx_q.size(), 32)
        for (n = 0; peer_u.rx_q.size() > 0; n++) begin
            e = peer_u.rx_q.pop_front();
            `CHK(e, n[7:0])
        end
        rchk(3'h5, 8'h60, 8'h60);
        // receive queue overrun, then drained in order
        for (n = 0; n < 33; n++)
            peer_u.send(8'hA0 + n[7:0], 1'b1);
        rchk(3'h5, 8'h03, 8'h03);
        for (n = 0; n < 32; n++)
            rchk(3'h0, 8'hFF, 8'hA0 + n[7:0]);
        rchk(3'h5, 8'h01, 8'h00);
        end_sim();
    end
endmodule : tb
